// ### vpic_pkg.sv
// vpic_pkg: constants shared by the vectored priority interrupt controller.
// assumes a 16-bit register port indexed by word, one clock domain.
package vpic_pkg;
    // register indices, one 16-bit word each
    localparam logic [4:0] IDX_CTRL_ONE = 5'h00;
    localparam logic [4:0] IDX_CTRL_TWO = 5'h01;
    localparam logic [4:0] IDX_FLAG_BASE = 5'h02;
    localparam logic [4:0] IDX_ENABLE_BASE = 5'h04;
    localparam logic [4:0] IDX_PRIO_BASE = 5'h06;
    localparam logic [4:0] IDX_PENDING = 5'h10;
    localparam logic [4:0] IDX_STATUS_WORD = 5'h11;
    localparam logic [4:0] IDX_CORE_CTRL = 5'h12;
    localparam int NUM_FLAG_REGS = 2;
    localparam int NUM_PRIO_REGS = 10;
    localparam int SLOTS_PER_PRIO = 5;
    localparam int NUM_SRC = 32;
    localparam int PRIO_W = 3;
    localparam int LEVEL_W = 4;
    localparam int VEC_W = 7;
    localparam int ADDR_W = 24;
    // global control one fields
    localparam int NEST_DIS_BIT = 15;
    localparam int DIV0_BIT = 6;
    localparam int MATH_BIT = 4;
    localparam int ADDRERR_BIT = 3;
    localparam int STACK_BIT = 2;
    localparam int OSC_BIT = 1;
    localparam logic [15:0] CTRL_ONE_WMASK = 16'h805e;
    // global control two fields
    localparam int ALT_SEL_BIT = 15;
    localparam int NUM_EXT = 3;
    localparam int EXT_SRC [NUM_EXT] = '{0, 20, 29};
    // status word, core control and pending status fields
    localparam int IPL_LSB = 5;
    localparam int IPL_MSB_BIT = 3;
    localparam int PEND_VEC_LSB = 0;
    localparam int PEND_LVL_LSB = 8;
    // vector numbering and handler table layout
    localparam logic [VEC_W-1:0] USER_VEC_OFFSET = 7'h08;
    localparam logic [VEC_W-1:0] TRAP_OSC_VEC = 7'h01;
    localparam logic [VEC_W-1:0] TRAP_ADDR_VEC = 7'h02;
    localparam logic [VEC_W-1:0] TRAP_STACK_VEC = 7'h03;
    localparam logic [VEC_W-1:0] TRAP_MATH_VEC = 7'h04;
    localparam logic [ADDR_W-1:0] TABLE_START = 24'h000004;
    localparam logic [ADDR_W-1:0] ALT_TABLE_OFFSET = 24'h000100;
    localparam logic [2:0] IPL_ALL_BLOCKED = 3'h7;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
endpackage : vpic_pkg

// ### vpic_ctrl.sv
// vpic_ctrl: vectored, prioritised interrupt controller with its registers.
// assumes same-clock one-cycle request pulses from peripherals and the cpu,
// asynchronous external pins, and a simple strobe register port.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module vpic_ctrl
    import vpic_pkg::*;
#(
    parameter logic [NUM_SRC-1:0] SRC_PRESENT = 32'hffff_ffff
) (
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [4:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [15:0] REG_RDATA_O,
    input wire logic [NUM_SRC-1:0] SRC_REQ_I,
    input wire logic [NUM_EXT-1:0] EXT_PIN_I,
    input wire logic [3:0] TRAP_I,
    input wire logic TRAP_DIV0_I,
    input wire logic CPU_LEVEL_LOAD_I,
    input wire logic [LEVEL_W-1:0] CPU_LEVEL_I,
    output logic [LEVEL_W-1:0] CPU_LEVEL_O,
    output logic IRQ_REQ_O,
    output logic [VEC_W-1:0] IRQ_VECTOR_O,
    output logic [LEVEL_W-1:0] IRQ_LEVEL_O,
    output logic [ADDR_W-1:0] IRQ_HANDLER_ADDR_O,
    output logic TRAP_PENDING_O,
    output logic [ADDR_W-1:0] TRAP_HANDLER_ADDR_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    // handler word address: table start plus two bytes per vector
    function automatic logic [ADDR_W-1:0] vpic_handler_addr(
        input logic [VEC_W-1:0] vec, input logic alt);
        logic [ADDR_W-1:0] base;
        base = TABLE_START + {16'h0000, vec, 1'b0};
        return alt ? base + ALT_TABLE_OFFSET : base;
    endfunction : vpic_handler_addr

    logic [15:0] ctrl_one_reg, ctrl_one_next;
    logic [15:0] ctrl_two_reg, ctrl_two_next;
    logic [NUM_SRC-1:0] flag_reg, flag_next;
    logic [NUM_SRC-1:0] en_reg, en_next;
    logic [PRIO_W-1:0] prio_reg [NUM_SRC];
    logic [PRIO_W-1:0] prio_next [NUM_SRC];
    logic [2:0] ipl_reg, ipl_next;
    logic ipl_msb_reg, ipl_msb_next;
    logic [NUM_EXT-1:0] ext_sync1_reg, ext_sync2_reg, ext_prev_reg;
    logic [NUM_EXT-1:0] ext_edge;
    logic [NUM_SRC-1:0] flag_set;
    logic flag_wr_any;
    logic [NUM_SRC-1:0] elig;
    logic found;
    logic [VEC_W-1:0] best_vec;
    logic [PRIO_W-1:0] best_prio;
    logic [VEC_W-1:0] vec_reg, vec_next;
    logic [LEVEL_W-1:0] lvl_reg, lvl_next;
    logic irq_reg, irq_next;
    logic [ADDR_W-1:0] haddr_reg, haddr_next;
    logic trap_reg, trap_next;
    logic [ADDR_W-1:0] taddr_reg, taddr_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [LEVEL_W-1:0] cpu_level;
    logic [2:0] wr_ipl;
    logic nest_dis, alt_sel;

    assign nest_dis = ctrl_one_reg[NEST_DIS_BIT];
    assign alt_sel = ctrl_two_reg[ALT_SEL_BIT];
    assign wr_ipl = REG_WDATA_I[IPL_LSB +: 3];
    assign cpu_level = {ipl_msb_reg, ipl_reg};

    // pin synchroniser and edge detect; polarity sits in control two
    always_comb begin
        for (int e = 0; e < NUM_EXT; e++) begin
            if (ctrl_two_reg[e])
                ext_edge[e] = ext_prev_reg[e] & ~ext_sync2_reg[e];
            else
                ext_edge[e] = ext_sync2_reg[e] & ~ext_prev_reg[e];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            ext_sync1_reg <= '0;
            ext_sync2_reg <= '0;
            ext_prev_reg <= '0;
        end else begin
            ext_sync1_reg <= EXT_PIN_I;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg <= ext_sync2_reg;
        end
    end

    // request sources: peripheral pulses plus pin edges at their slots
    always_comb begin
        flag_set = SRC_REQ_I;
        for (int e = 0; e < NUM_EXT; e++) begin
            flag_set[EXT_SRC[e]] = SRC_REQ_I[EXT_SRC[e]] | ext_edge[e];
        end
        flag_set = flag_set & SRC_PRESENT;
    end

    // flag, enable and priority registers; a set in the same cycle as a
    // software clear wins so that no request is ever lost
    always_comb begin
        flag_next = flag_reg;
        en_next = en_reg;
        flag_wr_any = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            prio_next[i] = prio_reg[i];
        end
        // ascending packing, source zero at bit zero
        for (int k = 0; k < NUM_FLAG_REGS; k++) begin
            if (REG_WR_I && REG_ADDR_I == IDX_FLAG_BASE + 5'(k)) begin
                flag_next[16*k +: 16] = REG_WDATA_I;
                flag_wr_any = 1'b1;
            end
            if (REG_WR_I && REG_ADDR_I == IDX_ENABLE_BASE + 5'(k))
                en_next[16*k +: 16] = REG_WDATA_I;
        end
        flag_next = (flag_next | flag_set) & SRC_PRESENT;
        en_next = en_next & SRC_PRESENT;
        for (int r = 0; r < NUM_PRIO_REGS; r++) begin
            for (int s = 0; s < SLOTS_PER_PRIO; s++) begin
                if (REG_WR_I && REG_ADDR_I == IDX_PRIO_BASE + 5'(r) &&
                    r * SLOTS_PER_PRIO + s < NUM_SRC)
                    prio_next[r * SLOTS_PER_PRIO + s] =
                        REG_WDATA_I[PRIO_W*s +: PRIO_W];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            flag_reg <= '0;
            en_reg <= '0;
            for (int i = 0; i < NUM_SRC; i++) begin
                prio_reg[i] <= PRIO_RESET;
            end
        end else begin
            flag_reg <= flag_next;
            en_reg <= en_next;
            prio_reg <= prio_next;
        end
    end

    // global controls; trap flags are sticky and set wins over a write
    always_comb begin
        ctrl_one_next = ctrl_one_reg;
        ctrl_two_next = ctrl_two_reg;
        if (REG_WR_I && REG_ADDR_I == IDX_CTRL_ONE)
            ctrl_one_next = REG_WDATA_I & CTRL_ONE_WMASK;
        ctrl_one_next[OSC_BIT] = ctrl_one_next[OSC_BIT] | TRAP_I[0];
        ctrl_one_next[ADDRERR_BIT] = ctrl_one_next[ADDRERR_BIT] | TRAP_I[1];
        ctrl_one_next[STACK_BIT] = ctrl_one_next[STACK_BIT] | TRAP_I[2];
        ctrl_one_next[MATH_BIT] = ctrl_one_next[MATH_BIT] | TRAP_I[3];
        ctrl_one_next[DIV0_BIT] = ctrl_one_next[DIV0_BIT] |
                                  (TRAP_I[3] & TRAP_DIV0_I);
        if (REG_WR_I && REG_ADDR_I == IDX_CTRL_TWO) begin
            ctrl_two_next = '0;
            ctrl_two_next[ALT_SEL_BIT] = REG_WDATA_I[ALT_SEL_BIT];
            ctrl_two_next[NUM_EXT-1:0] = REG_WDATA_I[NUM_EXT-1:0];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            ctrl_one_reg <= '0;
            ctrl_two_reg <= '0;
        end else begin
            ctrl_one_reg <= ctrl_one_next;
            ctrl_two_reg <= ctrl_two_next;
        end
    end

    // cpu level: the cpu load (entry/return) outranks a software write
    always_comb begin
        ipl_next = ipl_reg;
        ipl_msb_next = ipl_msb_reg;
        if (CPU_LEVEL_LOAD_I) begin
            ipl_msb_next = CPU_LEVEL_I[IPL_MSB_BIT];
            ipl_next = CPU_LEVEL_I[2:0];
        end else if (REG_WR_I && REG_ADDR_I == IDX_STATUS_WORD &&
                     !nest_dis) begin
            // software sets level, unless nesting off
            ipl_next = wr_ipl;
        end
        // no software path to the fourth bit
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            ipl_reg <= 3'h0;
            ipl_msb_reg <= 1'b0;
        end else begin
            ipl_reg <= ipl_next;
            ipl_msb_reg <= ipl_msb_next;
        end
    end

    // arbitration: strict greater-than in ascending order keeps the
    // lowest vector among equal priorities
    always_comb begin
        found = 1'b0;
        best_vec = '0;
        best_prio = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            // fall out of the level compare
            elig[i] = flag_reg[i] && en_reg[i] && SRC_PRESENT[i] &&
                      !ipl_msb_reg && ipl_reg != IPL_ALL_BLOCKED &&
                      {1'b0, prio_reg[i]} > cpu_level;
            if (elig[i] && (!found || prio_reg[i] > best_prio)) begin
                found = 1'b1;
                best_prio = prio_reg[i];
                best_vec = VEC_W'(i) + USER_VEC_OFFSET;
            end
        end
    end

    // presented interrupt and trap; the last vector latched stays readable
    always_comb begin
        vec_next = vec_reg;
        lvl_next = lvl_reg;
        haddr_next = haddr_reg;
        irq_next = found;
        // latch vector and level, level is priority
        if (found) begin
            vec_next = best_vec;
            lvl_next = {1'b0, best_prio};
            haddr_next = vpic_handler_addr(best_vec, alt_sel);
        end
        trap_next = ctrl_one_reg[OSC_BIT] | ctrl_one_reg[ADDRERR_BIT] |
                    ctrl_one_reg[STACK_BIT] | ctrl_one_reg[MATH_BIT];
        // trap handler word, lower trap vector first
        if (ctrl_one_reg[OSC_BIT])
            taddr_next = vpic_handler_addr(TRAP_OSC_VEC, alt_sel);
        else if (ctrl_one_reg[ADDRERR_BIT])
            taddr_next = vpic_handler_addr(TRAP_ADDR_VEC, alt_sel);
        else if (ctrl_one_reg[STACK_BIT])
            taddr_next = vpic_handler_addr(TRAP_STACK_VEC, alt_sel);
        else if (ctrl_one_reg[MATH_BIT])
            taddr_next = vpic_handler_addr(TRAP_MATH_VEC, alt_sel);
        else
            taddr_next = '0;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            vec_reg <= '0;
            lvl_reg <= '0;
            haddr_reg <= '0;
            irq_reg <= 1'b0;
            trap_reg <= 1'b0;
            taddr_reg <= '0;
        end else begin
            vec_reg <= vec_next;
            lvl_reg <= lvl_next;
            haddr_reg <= haddr_next;
            irq_reg <= irq_next;
            trap_reg <= trap_next;
            taddr_reg <= taddr_next;
        end
    end

    // read mux; data stand only in the cycle after the strobe
    always_comb begin
        rdata_next = '0;
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                IDX_CTRL_ONE: rdata_next = ctrl_one_reg;
                IDX_CTRL_TWO: rdata_next = ctrl_two_reg;
                IDX_PENDING: begin
                    rdata_next[PEND_VEC_LSB +: VEC_W] = vec_reg;
                    rdata_next[PEND_LVL_LSB +: LEVEL_W] = lvl_reg;
                end
                IDX_STATUS_WORD: rdata_next[IPL_LSB +: 3] = ipl_reg;
                IDX_CORE_CTRL: rdata_next[IPL_MSB_BIT] = ipl_msb_reg;
                default: begin
                    for (int k = 0; k < NUM_FLAG_REGS; k++) begin
                        if (REG_ADDR_I == IDX_FLAG_BASE + 5'(k))
                            rdata_next = flag_reg[16*k +: 16];
                        if (REG_ADDR_I == IDX_ENABLE_BASE + 5'(k))
                            rdata_next = en_reg[16*k +: 16];
                    end
                    for (int r = 0; r < NUM_PRIO_REGS; r++) begin
                        for (int s = 0; s < SLOTS_PER_PRIO; s++) begin
                            if (REG_ADDR_I == IDX_PRIO_BASE + 5'(r) &&
                                r * SLOTS_PER_PRIO + s < NUM_SRC)
                                rdata_next[PRIO_W*s +: PRIO_W] =
                                    prio_reg[r * SLOTS_PER_PRIO + s];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I)
            rdata_reg <= '0;
        else
            rdata_reg <= rdata_next;
    end

    assign REG_RDATA_O = rdata_reg;
    assign CPU_LEVEL_O = cpu_level;
    assign IRQ_REQ_O = irq_reg;
    assign IRQ_VECTOR_O = vec_reg;
    assign IRQ_LEVEL_O = lvl_reg;
    assign IRQ_HANDLER_ADDR_O = haddr_reg;
    assign TRAP_PENDING_O = trap_reg;
    assign TRAP_HANDLER_ADDR_O = taddr_reg;

    // checks on the behaviour above
    sequence s_ext0_rise;
        !ext_sync2_reg[0] ##1 (ext_sync2_reg[0] && !ctrl_two_reg[0]);
    endsequence
    property p_ext0_rise;
        s_ext0_rise |=> flag_reg[EXT_SRC[0]];
    endproperty
    a_ext0_rise: assert property (p_ext0_rise)
        else $error("rising edge on pin zero lost");
    property p_flag_hold;
        !flag_wr_any |=> (flag_reg & $past(flag_reg)) == $past(flag_reg);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("request flag cleared without software");
    property p_flag_set;
        flag_set != '0 |=> (flag_reg & $past(flag_set)) == $past(flag_set);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("request pulse did not set its flag");
    property p_latch_vec;
        found |=> IRQ_REQ_O && IRQ_VECTOR_O == $past(best_vec);
    endproperty
    a_latch_vec: assert property (p_latch_vec)
        else $error("vector number not latched");
    property p_latch_lvl;
        found |=> IRQ_LEVEL_O == {1'b0, $past(best_prio)};
    endproperty
    a_latch_lvl: assert property (p_latch_lvl)
        else $error("latched level differs from priority");
    property p_above_level;
        found |-> {1'b0, best_prio} > cpu_level;
    endproperty
    a_above_level: assert property (p_above_level)
        else $error("interrupt not above cpu level");
    property p_msb_blocks;
        ipl_msb_reg |=> !IRQ_REQ_O;
    endproperty
    a_msb_blocks: assert property (p_msb_blocks)
        else $error("user interrupt with fourth bit set");
    property p_seven_blocks;
        ipl_reg == IPL_ALL_BLOCKED |=> !IRQ_REQ_O;
    endproperty
    a_seven_blocks: assert property (p_seven_blocks)
        else $error("user interrupt at level seven");
    property p_nest_freeze;
        REG_WR_I && REG_ADDR_I == IDX_STATUS_WORD && nest_dis &&
        !CPU_LEVEL_LOAD_I |=> $stable(ipl_reg);
    endproperty
    a_nest_freeze: assert property (p_nest_freeze)
        else $error("level written while nesting disabled");
    property p_sw_level;
        REG_WR_I && REG_ADDR_I == IDX_STATUS_WORD && !nest_dis &&
        !CPU_LEVEL_LOAD_I |=> ipl_reg == $past(wr_ipl);
    endproperty
    a_sw_level: assert property (p_sw_level)
        else $error("software level write lost");
    property p_msb_ro;
        REG_WR_I && !CPU_LEVEL_LOAD_I |=> $stable(ipl_msb_reg);
    endproperty
    a_msb_ro: assert property (p_msb_ro)
        else $error("software changed fourth level bit");
    property p_reset_level;
        $fell(SYS_RST_I) |-> cpu_level == 4'h0;
    endproperty
    a_reset_level: assert property (p_reset_level)
        else $error("cpu level not zero after reset");
    property p_tie_low;
        elig[0] && prio_reg[0] == 3'h7 |-> best_vec == USER_VEC_OFFSET;
    endproperty
    a_tie_low: assert property (p_tie_low)
        else $error("lower vector lost a tie");
    property p_alt_addr;
        found |=> IRQ_HANDLER_ADDR_O ==
            vpic_handler_addr($past(best_vec), $past(alt_sel));
    endproperty
    a_alt_addr: assert property (p_alt_addr)
        else $error("handler address wrong for table");
endmodule : vpic_ctrl

// ### vpic_cpu_model.sv
// vpic_cpu_model: cpu side that takes interrupts and loads its level.
// assumes the controller's registered irq outputs and one clock.
`timescale 1ns/1ps
module vpic_cpu_model
    import vpic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_req_i,
    input wire logic [LEVEL_W-1:0] irq_level_i,
    input wire logic ack_en_i,
    input wire logic [3:0] lat_i,
    input wire logic cmd_i,
    input wire logic [LEVEL_W-1:0] cmd_level_i,
    output logic load_o,
    output logic [LEVEL_W-1:0] level_o
);
    logic [3:0] wait_reg;
    // level loaded on entry
    // level lines toggle while idle, so a stale value is never taken
    always @(posedge clk_i) begin
        load_o <= 1'b0;
        level_o <= ~level_o;
        if (rst_i) begin
            wait_reg <= 4'h0;
            level_o <= 4'h0;
        end else if (cmd_i) begin
            load_o <= 1'b1;
            level_o <= cmd_level_i;
        end else if (ack_en_i && irq_req_i && !load_o) begin
            wait_reg <= wait_reg + 4'h1;
            if (wait_reg == lat_i) begin
                load_o <= 1'b1;
                level_o <= irq_level_i;
                wait_reg <= 4'h0;
            end
        end
    end
endmodule : vpic_cpu_model

// ### tb_top.sv
// tb_top: self-checking bench for the interrupt controller.
// assumes the register port and cpu model above; expected from a model.
`timescale 1ns/1ps
module tb_top
    import vpic_pkg::*;
;
    logic clk, rst, wr, rd, ld, cmd, ack, div0, irq, tpend;
    logic [4:0] addr;
    logic [15:0] wdat, rdat, r, v;
    logic [31:0] req;
    logic [2:0] pin;
    logic [3:0] trap, lvl_in, cmd_lvl, lat, cpu_lvl, irq_lvl;
    logic [6:0] vec;
    logic [23:0] haddr, taddr;
    int fail_count, samples_checked, seed, lvl, nd, alt;
    int fl[32], en[32], pr[32];
    vpic_ctrl i_vpic_ctrl (.CORE_CLK_I(clk), .SYS_RST_I(rst),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdat), .SRC_REQ_I(req), .EXT_PIN_I(pin), .TRAP_I(trap),
        .TRAP_DIV0_I(div0), .CPU_LEVEL_LOAD_I(ld), .CPU_LEVEL_I(lvl_in),
        .CPU_LEVEL_O(cpu_lvl), .IRQ_REQ_O(irq), .IRQ_VECTOR_O(vec),
        .IRQ_LEVEL_O(irq_lvl), .IRQ_HANDLER_ADDR_O(haddr),
        .TRAP_PENDING_O(tpend), .TRAP_HANDLER_ADDR_O(taddr));
    vpic_cpu_model i_vpic_cpu_model (.clk_i(clk), .rst_i(rst),
        .irq_req_i(irq), .irq_level_i(irq_lvl), .ack_en_i(ack), .lat_i(lat),
        .cmd_i(cmd), .cmd_level_i(cmd_lvl), .load_o(ld), .level_o(lvl_in));
    // 100 MHz core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // write one word and mirror it in the model
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a == IDX_CTRL_ONE) nd = d[NEST_DIS_BIT];
        if (a == IDX_CTRL_TWO) alt = d[ALT_SEL_BIT];
        if (a == IDX_STATUS_WORD && !nd) lvl = (lvl & 8) | d[7:5];
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 2; k++) begin
                if (a == IDX_FLAG_BASE + k) fl[16*k+i] = d[i];
                if (a == IDX_ENABLE_BASE + k) en[16*k+i] = d[i];
            end
        end
        for (int s = 0; s < NUM_SRC; s++) begin
            if (a == IDX_PRIO_BASE + s / 5) pr[s] = d[3*(s%5)+:3];
        end
    endtask : wr_reg
    // read data stand only in the cycle after the read edge
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask : rd_reg
    task automatic pulse(input logic [31:0] m);
        @(posedge clk);
        req <= m;
        @(posedge clk);
        req <= '0;
        for (int i = 0; i < NUM_SRC; i++) fl[i] = fl[i] | m[i];
    endtask : pulse
    task automatic set_lvl(input logic [3:0] l);
        @(posedge clk);
        cmd <= 1'b1;
        cmd_lvl <= l;
        @(posedge clk);
        cmd <= 1'b0;
        lvl = l;
    endtask : set_lvl
    // model winner: highest priority above level, ties to lowest index
    task automatic chk_irq();
        int w;
        int bp;
        w = -1;
        bp = 0;
        repeat (3) @(posedge clk);
        #1;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (fl[i] && en[i] && lvl < 7 && pr[i] > lvl && pr[i] > bp) begin
                w = i;
                bp = pr[i];
            end
        end
        check(irq, w >= 0);
        if (w >= 0) begin
            check(vec, w + 8);
            check(irq_lvl, bp);
            check(haddr, 4 + 2 * (w + 8) + 256 * alt);
        end
    endtask : chk_irq
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
    initial begin
        seed = 32'hcfeb1a94;
        {rst, wr, rd, cmd, ack, div0} = 6'h20;
        {addr, wdat, req, pin, trap, cmd_lvl, lat} = '0;
        {lvl, nd, alt} = '0;
        for (int i = 0; i < 32; i++) {fl[i], en[i], pr[i]} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check(cpu_lvl, 0);
        rd_reg(IDX_STATUS_WORD, r);
        check(r, 0);
        rd_reg(5'h1f, r);
        check(r, 0);
        wr_reg(IDX_ENABLE_BASE, 16'hffff);
        wr_reg(IDX_ENABLE_BASE + 1, 16'hffff);
        // random priorities and requests against the model
        for (int n = 0; n < 4; n++) begin
            for (int p = 0; p < 7; p++) begin
                v = $random(seed) & 16'h7fff;
                wr_reg(IDX_PRIO_BASE + p, v);
                rd_reg(IDX_PRIO_BASE + p, r);
                check(r, (p == 6) ? (v & 16'h003f) : v);
            end
            wr_reg(IDX_FLAG_BASE, 16'h0000);
            wr_reg(IDX_FLAG_BASE + 1, 16'h0000);
            v = $random(seed);
            pulse({16'($random(seed)), v});
            chk_irq();
            rd_reg(IDX_FLAG_BASE, r);
            check(r, v);
            chk_irq();
        end
        // equal priorities: lowest source wins
        for (int p = 0; p < 7; p++) wr_reg(IDX_PRIO_BASE + p, 16'h4924);
        wr_reg(IDX_FLAG_BASE, 16'h0000);
        wr_reg(IDX_FLAG_BASE + 1, 16'h0000);
        pulse(32'h0000_0a00);
        chk_irq();
        wr_reg(IDX_ENABLE_BASE, 16'hfdff);
        chk_irq();
        wr_reg(IDX_STATUS_WORD, 16'h0080);
        chk_irq();
        wr_reg(IDX_PRIO_BASE + 2, 16'h493c);
        wr_reg(IDX_STATUS_WORD, 16'h00e0);
        chk_irq();
        wr_reg(IDX_STATUS_WORD, 16'h00c0);
        chk_irq();
        set_lvl(4'h8);
        chk_irq();
        check(cpu_lvl, 8);
        rd_reg(IDX_CORE_CTRL, r);
        check(r, 16'h0008);
        // read data stand one cycle only, then fall back to zero
        @(posedge clk);
        #1 check(rdat, 16'h0000);
        wr_reg(IDX_CORE_CTRL, 16'h0000);
        wr_reg(IDX_STATUS_WORD, 16'h0040);
        chk_irq();
        check(cpu_lvl, 4'ha);
        set_lvl(4'h0);
        wr_reg(IDX_CTRL_ONE, 16'h8000);
        wr_reg(IDX_STATUS_WORD, 16'h00e0);
        #1 check(cpu_lvl, 0);
        wr_reg(IDX_CTRL_ONE, 16'h0000);
        // cpu takes the interrupt after a random delay
        lat <= 4'($random(seed) & 3);
        ack <= 1'b1;
        repeat (12) @(posedge clk);
        ack <= 1'b0;
        lvl = 7;
        #1 check(cpu_lvl, 7);
        set_lvl(4'h0);
        wr_reg(IDX_CTRL_TWO, 16'h8000);
        chk_irq();
        @(posedge clk);
        trap <= 4'h8;
        div0 <= 1'b1;
        @(posedge clk);
        trap <= 4'h0;
        div0 <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check(tpend, 1);
        check(taddr, 24'h00010c);
        rd_reg(IDX_CTRL_ONE, r);
        check(r, 16'h0050);
        wr_reg(IDX_CTRL_TWO, 16'h0001);
        repeat (2) @(posedge clk);
        #1 check(taddr, 24'h00000c);
        // lower trap vectors outrank the sticky math trap
        @(posedge clk);
        trap <= 4'h4;
        @(posedge clk);
        trap <= 4'h0;
        repeat (3) @(posedge clk);
        #1 check(taddr, 24'h00000a);
        @(posedge clk);
        trap <= 4'h1;
        @(posedge clk);
        trap <= 4'h0;
        repeat (3) @(posedge clk);
        #1 check(taddr, 24'h000006);
        rd_reg(IDX_CTRL_ONE, r);
        check(r, 16'h0056);
        // falling polarity: a rising pin must not set the flag
        wr_reg(IDX_FLAG_BASE, 16'h0000);
        pin <= 3'b001;
        repeat (6) @(posedge clk);
        rd_reg(IDX_FLAG_BASE, r);
        check(r, 16'h0000);
        pin <= 3'b000;
        repeat (6) @(posedge clk);
        rd_reg(IDX_FLAG_BASE, r);
        check(r, 16'h0001);
        // rising polarity on all three pins: sources 0, 20 and 29
        wr_reg(IDX_CTRL_TWO, 16'h0000);
        wr_reg(IDX_FLAG_BASE, 16'h0000);
        wr_reg(IDX_FLAG_BASE + 1, 16'h0000);
        pin <= 3'b111;
        repeat (6) @(posedge clk);
        rd_reg(IDX_FLAG_BASE, r);
        check(r, 16'h0001);
        rd_reg(IDX_FLAG_BASE + 1, r);
        check(r, 16'h2010);
        end_of_test();
    end
endmodule : tb_top
